// File: design/ccdi_pkg.sv
package ccdi_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses on the bus)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CONFIG_CONTROL = 8'h00;
  localparam logic [7:0] OFF_DEVICE_IDENT   = 8'h04;
  localparam logic [7:0] OFF_RESET_CONTROL  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h10;
  localparam logic [7:0] OFF_PIN_REMAP      = 8'h14;
  localparam logic [7:0] OFF_MODULE_DISABLE = 8'h18;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int POS_PIN_REMAP_LOCK     = 13;
  localparam int POS_MODULE_DISABLE_LOCK = 12;
  localparam int POS_DEBUG_PORT_ENABLE  = 3;
  localparam int POS_TWO_WIRE_TDO_USE   = 0;
  localparam int POS_BROWN_OUT_FLAG     = 1;
  localparam int POS_IRQ_BROWN_OUT      = 0;
  localparam int POS_IRQ_LOCK_REFUSED   = 1;
  localparam int POS_IRQ_WRITE_BLOCKED  = 2;
  localparam int POS_IRQ_READY          = 3;
  localparam int IRQ_BITS               = 4;

  // ------------------------------------------------------------------
  // Reset values and fixed read patterns
  // ------------------------------------------------------------------
  localparam logic [31:0] CFG_FIXED_ONES   = 32'h0000_0006;
  localparam logic        RST_DEBUG_ENABLE = 1'b1;
  localparam logic        RST_TDO_USE      = 1'b1;
  localparam logic        RST_LOCK         = 1'b0;
  localparam logic [31:0] RST_REMAP        = 32'h0000_0000;
  localparam logic [31:0] RST_MODULE_DIS   = 32'h0000_0000;
  localparam logic [3:0]  RST_IRQ          = 4'h0;

  // Arbitrary identity values, not tied to any real part.
  localparam logic [3:0]  SILICON_REVISION = 4'h1;
  localparam logic [27:0] DEVICE_NUMBER    = 28'h000_0A5A;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int POWER_UP_HOLD_NS   = 10000;
  localparam int POWER_UP_HOLD_CYC  = (POWER_UP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    CCDI_PU_HOLD  = 2'b00,
    CCDI_PU_COUNT = 2'b01,
    CCDI_PU_RUN   = 2'b11
  } ccdi_pu_state_t;

endpackage

// File: design/ccdi_sync.sv
`timescale 1ns/10ps
module ccdi_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_sync
);

  logic stage_one;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stage_one <= 1'b0;
      o_sync    <= 1'b0;
    end
    else
    begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end

endmodule

// File: design/ccdi_power_up.sv
`timescale 1ns/10ps
module ccdi_power_up
#(
  parameter int HOLD_CYCLES = ccdi_pkg::POWER_UP_HOLD_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_power_down,
  output logic      o_run
);

  // ------------------------------------------------------------------
  // Execution hold-off after any power-down
  // ------------------------------------------------------------------
  ccdi_pkg::ccdi_pu_state_t state;
  logic [15:0]              count;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_power_down)
    begin
      state <= ccdi_pkg::CCDI_PU_HOLD;
      count <= 16'h0000;
      o_run <= 1'b0;
    end
    else
    begin
      case (state)
        ccdi_pkg::CCDI_PU_HOLD:
        begin
          state <= ccdi_pkg::CCDI_PU_COUNT;
          count <= 16'h0001;
        end
        ccdi_pkg::CCDI_PU_COUNT:
        begin
          if (count >= 16'(HOLD_CYCLES))
          begin
            state <= ccdi_pkg::CCDI_PU_RUN;
            o_run <= 1'b1;
          end
          else
          begin
            count <= count + 16'h0001;
          end
        end
        ccdi_pkg::CCDI_PU_RUN:
        begin
          o_run <= 1'b1;
        end
        default:
        begin
          state <= ccdi_pkg::CCDI_PU_HOLD;
        end
      endcase
    end
  end

endmodule

// File: design/ccdi_top.sv
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module ccdi_top
#(
  parameter int HOLD_CYCLES = ccdi_pkg::POWER_UP_HOLD_CYC
)
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  input  wire logic        I_SYSTEM_UNLOCKED,
  input  wire logic        I_SUPPLY_LOW,
  input  wire logic        I_POWER_DOWN,
  output logic             O_PIN_REMAP_LOCK,
  output logic             O_MODULE_DISABLE_LOCK,
  output logic             O_DEBUG_PORT_ENABLE,
  output logic             O_TWO_WIRE_TEST_OUT_USE,
  output logic      [31:0] O_PIN_REMAP_SELECT,
  output logic      [31:0] O_MODULE_POWER_DISABLE,
  output logic             O_BROWN_OUT_RESET,
  output logic             O_EXEC_ENABLE,
  output logic             O_IRQ
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic unlocked_s;
  logic supply_low_s;
  logic power_down_s;

  ccdi_sync u_sync_unlock
  (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_async (I_SYSTEM_UNLOCKED),
    .o_sync  (unlocked_s)
  );

  ccdi_sync u_sync_supply
  (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_async (I_SUPPLY_LOW),
    .o_sync  (supply_low_s)
  );

  ccdi_sync u_sync_power
  (
    .i_clk   (I_CLK),
    .i_rst   (I_RST),
    .i_async (I_POWER_DOWN),
    .o_sync  (power_down_s)
  );

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  logic request;
  logic wr;
  logic wr_byte1;
  logic wr_byte0;

  assign request  = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wr       = request && I_WB_WE;
  assign wr_byte1 = wr && I_WB_SEL[1];
  assign wr_byte0 = wr && I_WB_SEL[0];

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_WB_ACK <= 1'b0;
    end
    else
    begin
      O_WB_ACK <= request;
    end
  end

  // ------------------------------------------------------------------
  // Configuration control
  // ------------------------------------------------------------------
  logic lock_wr;
  logic lock_refused;

  assign lock_wr      = wr_byte1 && hit(I_WB_ADR, ccdi_pkg::OFF_CONFIG_CONTROL);
  assign lock_refused = lock_wr && !unlocked_s;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_PIN_REMAP_LOCK      <= ccdi_pkg::RST_LOCK;
      O_MODULE_DISABLE_LOCK <= ccdi_pkg::RST_LOCK;
    end
    else if (lock_wr && unlocked_s)
    begin
      O_PIN_REMAP_LOCK      <= I_WB_DAT[ccdi_pkg::POS_PIN_REMAP_LOCK];
      O_MODULE_DISABLE_LOCK <= I_WB_DAT[ccdi_pkg::POS_MODULE_DISABLE_LOCK];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_DEBUG_PORT_ENABLE     <= ccdi_pkg::RST_DEBUG_ENABLE;
      O_TWO_WIRE_TEST_OUT_USE <= ccdi_pkg::RST_TDO_USE;
    end
    else if (wr_byte0 && hit(I_WB_ADR, ccdi_pkg::OFF_CONFIG_CONTROL))
    begin
      O_DEBUG_PORT_ENABLE     <= I_WB_DAT[ccdi_pkg::POS_DEBUG_PORT_ENABLE];
      O_TWO_WIRE_TEST_OUT_USE <= I_WB_DAT[ccdi_pkg::POS_TWO_WIRE_TDO_USE];
    end
  end

  // ------------------------------------------------------------------
  // Guarded register groups
  // ------------------------------------------------------------------
  logic remap_wr;
  logic disable_wr;

  assign remap_wr   = wr && hit(I_WB_ADR, ccdi_pkg::OFF_PIN_REMAP);
  assign disable_wr = wr && hit(I_WB_ADR, ccdi_pkg::OFF_MODULE_DISABLE);

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_PIN_REMAP_SELECT <= ccdi_pkg::RST_REMAP;
    end
    else if (remap_wr && !O_PIN_REMAP_LOCK)
    begin
      O_PIN_REMAP_SELECT <= merge_bytes(O_PIN_REMAP_SELECT, I_WB_DAT, I_WB_SEL);
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_MODULE_POWER_DISABLE <= ccdi_pkg::RST_MODULE_DIS;
    end
    else if (disable_wr && !O_MODULE_DISABLE_LOCK)
    begin
      O_MODULE_POWER_DISABLE <= merge_bytes(O_MODULE_POWER_DISABLE, I_WB_DAT, I_WB_SEL);
    end
  end

  // ------------------------------------------------------------------
  // Brown-out and power-up
  // ------------------------------------------------------------------
  // The flag lives outside the reset it causes, so it survives the
  // brown-out reset; only the block reset or software clears it.
  logic brown_out_flag;
  logic supply_low_d;
  logic brown_out_event;

  assign brown_out_event = supply_low_s && !supply_low_d;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      supply_low_d      <= 1'b0;
      O_BROWN_OUT_RESET <= 1'b0;
    end
    else
    begin
      supply_low_d      <= supply_low_s;
      O_BROWN_OUT_RESET <= supply_low_s;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      brown_out_flag <= 1'b0;
    end
    else if (brown_out_event)
    begin
      brown_out_flag <= 1'b1;
    end
    else if (wr_byte0 && hit(I_WB_ADR, ccdi_pkg::OFF_RESET_CONTROL) && !I_WB_DAT[ccdi_pkg::POS_BROWN_OUT_FLAG])
    begin
      brown_out_flag <= 1'b0;
    end
  end

  logic pu_run;

  ccdi_power_up #(.HOLD_CYCLES(HOLD_CYCLES)) u_power_up
  (
    .i_clk        (I_CLK),
    .i_rst        (I_RST),
    .i_power_down (power_down_s || supply_low_s),
    .o_run        (pu_run)
  );

  logic pu_run_d;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_EXEC_ENABLE <= 1'b0;
      pu_run_d      <= 1'b0;
    end
    else
    begin
      O_EXEC_ENABLE <= pu_run;
      pu_run_d      <= pu_run;
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [ccdi_pkg::IRQ_BITS-1:0] irq_status;
  logic [ccdi_pkg::IRQ_BITS-1:0] irq_mask;
  logic [ccdi_pkg::IRQ_BITS-1:0] irq_set;
  logic [ccdi_pkg::IRQ_BITS-1:0] irq_clr;

  always_comb
  begin
    irq_set = '0;
    irq_set[ccdi_pkg::POS_IRQ_BROWN_OUT]    = brown_out_event;
    irq_set[ccdi_pkg::POS_IRQ_LOCK_REFUSED] = lock_refused;
    irq_set[ccdi_pkg::POS_IRQ_WRITE_BLOCKED] = (remap_wr && O_PIN_REMAP_LOCK) ||
                                               (disable_wr && O_MODULE_DISABLE_LOCK);
    irq_set[ccdi_pkg::POS_IRQ_READY]        = pu_run && !pu_run_d;
  end

  assign irq_clr = (wr_byte0 && hit(I_WB_ADR, ccdi_pkg::OFF_IRQ_STATUS)) ?
                   I_WB_DAT[ccdi_pkg::IRQ_BITS-1:0] : '0;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      irq_status <= ccdi_pkg::RST_IRQ;
    end
    else
    begin
      // Set wins over a clear landing in the same cycle.
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      irq_mask <= ccdi_pkg::RST_IRQ;
    end
    else if (wr_byte0 && hit(I_WB_ADR, ccdi_pkg::OFF_IRQ_MASK))
    begin
      irq_mask <= I_WB_DAT[ccdi_pkg::IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_IRQ <= 1'b0;
    end
    else
    begin
      O_IRQ <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (I_WB_ADR)
      ccdi_pkg::OFF_CONFIG_CONTROL:
      begin
        next_rdata = ccdi_pkg::CFG_FIXED_ONES;
        next_rdata[ccdi_pkg::POS_PIN_REMAP_LOCK]      = O_PIN_REMAP_LOCK;
        next_rdata[ccdi_pkg::POS_MODULE_DISABLE_LOCK] = O_MODULE_DISABLE_LOCK;
        next_rdata[ccdi_pkg::POS_DEBUG_PORT_ENABLE]   = O_DEBUG_PORT_ENABLE;
        next_rdata[ccdi_pkg::POS_TWO_WIRE_TDO_USE]    = O_TWO_WIRE_TEST_OUT_USE;
      end
      ccdi_pkg::OFF_DEVICE_IDENT:
      begin
        next_rdata = {ccdi_pkg::SILICON_REVISION, ccdi_pkg::DEVICE_NUMBER};
      end
      ccdi_pkg::OFF_RESET_CONTROL:
      begin
        next_rdata[ccdi_pkg::POS_BROWN_OUT_FLAG] = brown_out_flag;
      end
      ccdi_pkg::OFF_IRQ_STATUS:
      begin
        next_rdata[ccdi_pkg::IRQ_BITS-1:0] = irq_status;
      end
      ccdi_pkg::OFF_IRQ_MASK:
      begin
        next_rdata[ccdi_pkg::IRQ_BITS-1:0] = irq_mask;
      end
      ccdi_pkg::OFF_PIN_REMAP:
      begin
        next_rdata = O_PIN_REMAP_SELECT;
      end
      ccdi_pkg::OFF_MODULE_DISABLE:
      begin
        next_rdata = O_MODULE_POWER_DISABLE;
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_WB_DAT <= 32'h0000_0000;
    end
    else if (request && !I_WB_WE)
    begin
      O_WB_DAT <= next_rdata;
    end
  end

endmodule

// File: testbench/ccdi_checker.sv
`timescale 1ns/10ps
module ccdi_checker
#(
  parameter int HOLD_CYCLES = 4
)
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic        O_WB_ACK,
  input wire logic        I_SYSTEM_UNLOCKED,
  input wire logic        I_SUPPLY_LOW,
  input wire logic        I_POWER_DOWN,
  input wire logic        O_PIN_REMAP_LOCK,
  input wire logic        O_MODULE_DISABLE_LOCK,
  input wire logic        O_DEBUG_PORT_ENABLE,
  input wire logic        O_TWO_WIRE_TEST_OUT_USE,
  input wire logic [31:0] O_PIN_REMAP_SELECT,
  input wire logic [31:0] O_MODULE_POWER_DISABLE,
  input wire logic        O_BROWN_OUT_RESET,
  input wire logic        O_EXEC_ENABLE
);
  // --------------------
  // Helpers
  // --------------------
  // Counts idle cycles so a short hold-off shows up as a low count.
  int   low_cnt;
  logic cfg_wr;
  assign cfg_wr = I_WB_CYC && I_WB_STB && !O_WB_ACK && I_WB_WE && (I_WB_ADR == 8'h00);
  always_ff @(posedge I_CLK)
  begin
    if (I_RST || O_EXEC_ENABLE)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence req_s;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence ack_s;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  // --------------------
  // Properties
  // --------------------
  AST_ACK_ONE_CYCLE: assert property (req_s |=> ack_s)
    else $error("ack not a single pulse one cycle after request");
  AST_REMAP_LOCKED: assert property (O_PIN_REMAP_LOCK |=> $stable(O_PIN_REMAP_SELECT))
    else $error("remap select changed while locked");
  AST_DISABLE_LOCKED: assert property (O_MODULE_DISABLE_LOCK |=> $stable(O_MODULE_POWER_DISABLE))
    else $error("module disable changed while locked");
  AST_LOCK_NEEDS_UNLOCK: assert property ($changed({O_PIN_REMAP_LOCK, O_MODULE_DISABLE_LOCK})
    |-> $past(I_SYSTEM_UNLOCKED, 3))
    else $error("lock bit changed without unlock flag");
  AST_RESET_VALUES: assert property ($fell(I_RST) |-> O_DEBUG_PORT_ENABLE && O_TWO_WIRE_TEST_OUT_USE
    && !O_PIN_REMAP_LOCK && !O_MODULE_DISABLE_LOCK && !O_EXEC_ENABLE)
    else $error("wrong control values after reset");
  AST_CTRL_STABLE: assert property (!cfg_wr |=> $stable({O_DEBUG_PORT_ENABLE, O_TWO_WIRE_TEST_OUT_USE}))
    else $error("control bits changed without a config write");
  AST_BROWN_OUT_SET: assert property (I_SUPPLY_LOW [*5] |-> O_BROWN_OUT_RESET)
    else $error("brown-out reset missing under low supply");
  AST_BROWN_OUT_CLEAR: assert property (!I_SUPPLY_LOW [*5] |-> !O_BROWN_OUT_RESET)
    else $error("brown-out reset with good supply");
  AST_POWER_DOWN_HOLD: assert property (I_POWER_DOWN [*5] |-> !O_EXEC_ENABLE)
    else $error("execution enabled while powered down");
  AST_EXEC_DELAY: assert property ($rose(O_EXEC_ENABLE) |-> low_cnt >= HOLD_CYCLES)
    else $error("execution resumed before hold-off elapsed");
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // --------------------
  // Signals
  // --------------------
  localparam int HOLD = 4;
  logic        clk, rst, cyc, stb, we, unl, slow, pdn;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, remap, mdis, q;
  logic        ack, prl, mdl, dbg, two, bor, exe, irq;
  int          failures, check_count, n;

  // The short hold-off keeps the run brief; expectations use HOLD.
  ccdi_top #(.HOLD_CYCLES(HOLD)) dut (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_SYSTEM_UNLOCKED(unl), .I_SUPPLY_LOW(slow), .I_POWER_DOWN(pdn), .O_PIN_REMAP_LOCK(prl),
    .O_MODULE_DISABLE_LOCK(mdl), .O_DEBUG_PORT_ENABLE(dbg), .O_TWO_WIRE_TEST_OUT_USE(two),
    .O_PIN_REMAP_SELECT(remap), .O_MODULE_POWER_DISABLE(mdis), .O_BROWN_OUT_RESET(bor),
    .O_EXEC_ENABLE(exe), .O_IRQ(irq));

  // --------------------
  // Common tasks
  // --------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled high, then releases it.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'h1 && k < 20);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (ack !== 1'h1)
    begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic wait_exec();
    n = 0;
    while (exe !== 1'h1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    if (exe !== 1'h1)
    begin
      failures++;
      print_verdict();
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset_vals();
    chk(dbg, 1'h1, "debug enable");
    chk(two, 1'h1, "test out use");
    chk({prl, mdl}, 2'h0, "locks");
    chk(exe, 1'h0, "exec in reset");
    wait_exec();
    chk(n >= HOLD, 1'h1, "exec delay");
    wb(1'h0, ccdi_pkg::OFF_CONFIG_CONTROL, 32'h0, 4'hF);
    chk(q, 32'h0000_000F, "config reset");
  endtask

  task automatic t_ident();
    wb(1'h1, ccdi_pkg::OFF_DEVICE_IDENT, 32'hFFFF_FFFF, 4'hF);
    wb(1'h0, ccdi_pkg::OFF_DEVICE_IDENT, 32'h0, 4'hF);
    chk(q, {ccdi_pkg::SILICON_REVISION, ccdi_pkg::DEVICE_NUMBER}, "ident");
    wb(1'h0, 8'h1C, 32'h0, 4'hF);
    chk(q, 32'h0, "unmapped read");
  endtask

  task automatic t_lock_refused();
    wb(1'h1, ccdi_pkg::OFF_IRQ_MASK, 32'h2, 4'hF);
    wb(1'h1, ccdi_pkg::OFF_CONFIG_CONTROL, 32'hFFFF_FFFF, 4'hF);
    chk({prl, mdl}, 2'h0, "refused locks");
    chk(irq, 1'h1, "irq on refusal");
    wb(1'h0, ccdi_pkg::OFF_CONFIG_CONTROL, 32'h0, 4'hF);
    chk(q, 32'h0000_000F, "config refused");
    wb(1'h1, ccdi_pkg::OFF_IRQ_STATUS, 32'h2, 4'hF);
    @(posedge clk);
    chk(irq, 1'h0, "irq cleared");
    wb(1'h1, ccdi_pkg::OFF_IRQ_MASK, 32'h0, 4'hF);
  endtask

  task automatic t_locks();
    unl <= 1'h1;
    repeat (4) @(posedge clk);
    wb(1'h1, ccdi_pkg::OFF_PIN_REMAP, 32'hA5A5_0001, 4'hF);
    chk(remap, 32'hA5A5_0001, "remap open");
    wb(1'h1, ccdi_pkg::OFF_MODULE_DISABLE, 32'h0000_00F0, 4'hF);
    chk(mdis, 32'h0000_00F0, "disable open");
    wb(1'h1, ccdi_pkg::OFF_CONFIG_CONTROL, 32'hFFFF_FFFF, 4'hF);
    chk({prl, mdl}, 2'h3, "locks set");
    wb(1'h0, ccdi_pkg::OFF_CONFIG_CONTROL, 32'h0, 4'hF);
    chk(q, 32'h0000_300F, "config locked");
    wb(1'h1, ccdi_pkg::OFF_PIN_REMAP, 32'h0, 4'hF);
    chk(remap, 32'hA5A5_0001, "remap locked");
    wb(1'h0, ccdi_pkg::OFF_IRQ_STATUS, 32'h0, 4'hF);
    chk(q[ccdi_pkg::POS_IRQ_WRITE_BLOCKED], 1'h1, "blocked write status");
    wb(1'h1, ccdi_pkg::OFF_MODULE_DISABLE, 32'h0, 4'hF);
    chk(mdis, 32'h0000_00F0, "disable locked");
    wb(1'h1, ccdi_pkg::OFF_CONFIG_CONTROL, 32'h0, 4'hF);
    chk({dbg, two, prl, mdl}, 4'h0, "controls off");
    wb(1'h0, ccdi_pkg::OFF_CONFIG_CONTROL, 32'h0, 4'hF);
    chk(q, 32'h0000_0006, "config cleared");
    wb(1'h1, ccdi_pkg::OFF_PIN_REMAP, 32'h0, 4'hF);
    chk(remap, 32'h0, "remap reopened");
    unl <= 1'h0;
  endtask

  task automatic t_brown_out();
    slow <= 1'h1;
    repeat (5) @(posedge clk);
    chk(bor, 1'h1, "brown-out reset");
    slow <= 1'h0;
    wb(1'h0, ccdi_pkg::OFF_RESET_CONTROL, 32'h0, 4'hF);
    chk(q[1], 1'h1, "brown-out flag");
    wb(1'h0, ccdi_pkg::OFF_IRQ_STATUS, 32'h0, 4'hF);
    chk(q[ccdi_pkg::POS_IRQ_BROWN_OUT], 1'h1, "brown-out status");
    repeat (5) @(posedge clk);
    chk(bor, 1'h0, "brown-out released");
    wb(1'h1, ccdi_pkg::OFF_RESET_CONTROL, 32'h0, 4'h1);
    wb(1'h0, ccdi_pkg::OFF_RESET_CONTROL, 32'h0, 4'hF);
    chk(q[1], 1'h0, "flag cleared");
  endtask

  task automatic t_power();
    pdn <= 1'h1;
    repeat (6) @(posedge clk);
    chk(exe, 1'h0, "exec in sleep");
    pdn <= 1'h0;
    wait_exec();
    chk(n >= HOLD, 1'h1, "wake delay");
  endtask

  // --------------------
  // Run
  // --------------------
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst = 1'h1;
    {cyc, stb, we, unl, slow, pdn} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset_vals();
    t_ident();
    t_lock_refused();
    t_locks();
    t_brown_out();
    t_power();
    print_verdict();
  end
endmodule

bind ccdi_top ccdi_checker #(.HOLD_CYCLES(HOLD_CYCLES)) chk_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
  .O_WB_ACK(O_WB_ACK), .I_SYSTEM_UNLOCKED(I_SYSTEM_UNLOCKED), .I_SUPPLY_LOW(I_SUPPLY_LOW),
  .I_POWER_DOWN(I_POWER_DOWN), .O_PIN_REMAP_LOCK(O_PIN_REMAP_LOCK),
  .O_MODULE_DISABLE_LOCK(O_MODULE_DISABLE_LOCK), .O_DEBUG_PORT_ENABLE(O_DEBUG_PORT_ENABLE),
  .O_TWO_WIRE_TEST_OUT_USE(O_TWO_WIRE_TEST_OUT_USE), .O_PIN_REMAP_SELECT(O_PIN_REMAP_SELECT),
  .O_MODULE_POWER_DISABLE(O_MODULE_POWER_DISABLE), .O_BROWN_OUT_RESET(O_BROWN_OUT_RESET),
  .O_EXEC_ENABLE(O_EXEC_ENABLE));
